// file: rtl/pdl_defines.svh
// Register offsets and reset values of the port data block.
// Assumes inclusion by bare name from the package or the design files.
`ifndef PDL_DEFINES_SVH
`define PDL_DEFINES_SVH
// Printed offsets are not all word multiples, so they are indices
`define PDL_IDX_SINK_ENABLE   12'hf82
`define PDL_IDX_SINK_LVL_UP   12'hf83
`define PDL_IDX_SINK_LVL_LO   12'hf84
`define PDL_IDX_PA_IN         12'hfd2
`define PDL_IDX_PA_OUT        12'hfd3
`define PDL_IDX_PB_IN         12'hfd6
`define PDL_IDX_PB_OUT        12'hfd7
`define PDL_IDX_PC_IN         12'hfda
`define PDL_IDX_PC_OUT        12'hfdb
`define PDL_IDX_PD_IN         12'hfde
`define PDL_IDX_PD_OUT        12'hfdf
`define PDL_IDX_PA_DIR        12'hfe0
`define PDL_IDX_PB_DIR        12'hfe1
`define PDL_IDX_PC_DIR        12'hfe2
`define PDL_IDX_PD_DIR        12'hfe3
`define PDL_IDX_PA_ALT        12'hfe4
`define PDL_IDX_PB_ALT        12'hfe5
`define PDL_IDX_PC_ALT        12'hfe6
`define PDL_IDX_PD_ALT        12'hfe7
`define PDL_IDX_PA_OD         12'hfe8
`define PDL_IDX_PB_OD         12'hfe9
`define PDL_IDX_PC_OD         12'hfea
`define PDL_IDX_PD_OD         12'hfeb
`define PDL_RESET_BYTE        8'h00
`define PDL_ZERO_WORD         32'h0000_0000
`endif

// file: rtl/pdl_pin_drive.sv
// One port's pin driver: output value, direction, alternate and open drain.
// Assumes direction 1 means output; alternate pins are driven elsewhere.
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_pin_drive
  import pdl_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire pdl_byte_t outValue,
  input  wire pdl_byte_t dirOut,
  input  wire pdl_byte_t altFunc,
  input  wire pdl_byte_t openDrain,
  output pdl_byte_t      pinOut,
  output pdl_byte_t      pinOe_n
);
  typedef struct packed {
    pdl_byte_t pinOut;
    pdl_byte_t pinOe_n;
  } pdl_drv_s;
  pdl_drv_s state;
  pdl_drv_s next_state;
  // Drive only plain outputs; open drain releases the high level
  always_comb begin
    next_state.pinOut = outValue;
    next_state.pinOe_n = ~(dirOut & ~altFunc
                           & ~(openDrain & outValue));
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state.pinOut <= `PDL_RESET_BYTE;
      state.pinOe_n <= 8'hff;
    end else begin
      state <= next_state;
    end
  end
  assign pinOut = state.pinOut;
  assign pinOe_n = state.pinOe_n;
endmodule

// file: rtl/pdl_pkg.sv
// Types shared by the port data and sink drive design files.
// Assumes the defines header is on the include path.
package pdl_pkg;
  `include "pdl_defines.svh"
  typedef logic [7:0] pdl_byte_t;
  typedef logic [1:0] pdl_level_t;
  typedef enum logic [1:0] {
    PDL_SINK_3MA,
    PDL_SINK_7MA,
    PDL_SINK_13MA,
    PDL_SINK_20MA
  } pdl_sink_e;
endpackage

// file: rtl/pdl_port_data_led_drive.sv
// Port data registers, pin drivers and Port C current sink control on APB.
// Assumes synchronous pins, one clock and a synchronous active-low reset.
// Notes on behaviour
// - Input read returns sampled pin levels
// - Inputs read-only; absent port reads zero
// - Output driven only if output, not alternate
// - Open drain never drives high
// - Output and sink registers reset zero, RW
// - Sink enable bit connects Port C sink
// - Sink ignores alternate function selection
// - Level bit pair selects 3/7/13/20 mA
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_port_data_led_drive
  import pdl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pdl_byte_t   portAIn,
  input  wire pdl_byte_t   portBIn,
  input  wire pdl_byte_t   portCIn,
  output pdl_byte_t        portAOut,
  output pdl_byte_t        portAOe_n,
  output pdl_byte_t        portBOut,
  output pdl_byte_t        portBOe_n,
  output pdl_byte_t        portCOut,
  output pdl_byte_t        portCOe_n,
  output pdl_byte_t        portDOut,
  output pdl_byte_t        portDOe_n,
  output pdl_byte_t        sinkEnable,
  output pdl_byte_t        sinkLevelUpper,
  output pdl_byte_t        sinkLevelLower
);
  typedef struct packed {
    pdl_byte_t   samA;
    pdl_byte_t   samB;
    pdl_byte_t   samC;
    pdl_byte_t   [3:0] outVal;
    pdl_byte_t   [3:0] dir;
    pdl_byte_t   [3:0] alt;
    pdl_byte_t   [3:0] od;
    pdl_byte_t   sinkEn;
    pdl_byte_t   lvlUp;
    pdl_byte_t   lvlLo;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } pdl_top_s;
  pdl_top_s state;
  pdl_top_s next_state;
  logic [11:0] regIdx;
  logic        access;
  logic        wrTake;
  logic        mapped;
  logic [31:0] readWord;
  pdl_byte_t   [3:0] pinO;
  pdl_byte_t   [3:0] pinOe;

  // Byte index is the word address; low two address bits must be zero
  function automatic logic [11:0] toIndex(input logic [15:0] a);
    return a[13:2];
  endfunction

  // Current in mA of one pin's level pair, for checks
  function automatic int sinkMilliamp(input pdl_level_t lv);
    case (pdl_sink_e'(lv))
      PDL_SINK_3MA:  return 3;
      PDL_SINK_7MA:  return 7;
      PDL_SINK_13MA: return 13;
      default:       return 20;
    endcase
  endfunction

  assign regIdx = toIndex(paddr);
  assign access = psel && penable && !state.ready;
  // A write lands only at the edge where pready is seen high
  assign wrTake = psel && penable && pwrite && state.ready && mapped
                  && pstrb[0];

  // Read decode; port D has no input sampling and reads zero
  always_comb begin
    mapped = 1'b1;
    readWord = `PDL_ZERO_WORD;
    case (regIdx)
      `PDL_IDX_PA_IN:       readWord[7:0] = state.samA;
      `PDL_IDX_PB_IN:       readWord[7:0] = state.samB;
      `PDL_IDX_PC_IN:       readWord[7:0] = state.samC;
      `PDL_IDX_PD_IN:       readWord[7:0] = `PDL_RESET_BYTE;
      `PDL_IDX_PA_OUT:      readWord[7:0] = state.outVal[0];
      `PDL_IDX_PB_OUT:      readWord[7:0] = state.outVal[1];
      `PDL_IDX_PC_OUT:      readWord[7:0] = state.outVal[2];
      `PDL_IDX_PD_OUT:      readWord[7:0] = state.outVal[3];
      `PDL_IDX_PA_DIR:      readWord[7:0] = state.dir[0];
      `PDL_IDX_PB_DIR:      readWord[7:0] = state.dir[1];
      `PDL_IDX_PC_DIR:      readWord[7:0] = state.dir[2];
      `PDL_IDX_PD_DIR:      readWord[7:0] = state.dir[3];
      `PDL_IDX_PA_ALT:      readWord[7:0] = state.alt[0];
      `PDL_IDX_PB_ALT:      readWord[7:0] = state.alt[1];
      `PDL_IDX_PC_ALT:      readWord[7:0] = state.alt[2];
      `PDL_IDX_PD_ALT:      readWord[7:0] = state.alt[3];
      `PDL_IDX_PA_OD:       readWord[7:0] = state.od[0];
      `PDL_IDX_PB_OD:       readWord[7:0] = state.od[1];
      `PDL_IDX_PC_OD:       readWord[7:0] = state.od[2];
      `PDL_IDX_PD_OD:       readWord[7:0] = state.od[3];
      `PDL_IDX_SINK_ENABLE: readWord[7:0] = state.sinkEn;
      `PDL_IDX_SINK_LVL_UP: readWord[7:0] = state.lvlUp;
      `PDL_IDX_SINK_LVL_LO: readWord[7:0] = state.lvlLo;
      default:              mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[15:14] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // Register update; answers every access after one wait cycle
  always_comb begin
    next_state = state;
    next_state.samA = portAIn;
    next_state.samB = portBIn;
    next_state.samC = portCIn;
    next_state.ready = access;
    next_state.err = access && !mapped;
    next_state.rdata = (access && !pwrite && mapped) ? readWord
                                                     : `PDL_ZERO_WORD;
    // Writes land as the transfer completes; input indices fall through,
    // so a stray write there leaves every register alone
    if (wrTake) begin
      case (regIdx)
        `PDL_IDX_PA_OUT:      next_state.outVal[0] = pwdata[7:0];
        `PDL_IDX_PB_OUT:      next_state.outVal[1] = pwdata[7:0];
        `PDL_IDX_PC_OUT:      next_state.outVal[2] = pwdata[7:0];
        `PDL_IDX_PD_OUT:      next_state.outVal[3] = pwdata[7:0];
        `PDL_IDX_PA_DIR:      next_state.dir[0] = pwdata[7:0];
        `PDL_IDX_PB_DIR:      next_state.dir[1] = pwdata[7:0];
        `PDL_IDX_PC_DIR:      next_state.dir[2] = pwdata[7:0];
        `PDL_IDX_PD_DIR:      next_state.dir[3] = pwdata[7:0];
        `PDL_IDX_PA_ALT:      next_state.alt[0] = pwdata[7:0];
        `PDL_IDX_PB_ALT:      next_state.alt[1] = pwdata[7:0];
        `PDL_IDX_PC_ALT:      next_state.alt[2] = pwdata[7:0];
        `PDL_IDX_PD_ALT:      next_state.alt[3] = pwdata[7:0];
        `PDL_IDX_PA_OD:       next_state.od[0] = pwdata[7:0];
        `PDL_IDX_PB_OD:       next_state.od[1] = pwdata[7:0];
        `PDL_IDX_PC_OD:       next_state.od[2] = pwdata[7:0];
        `PDL_IDX_PD_OD:       next_state.od[3] = pwdata[7:0];
        `PDL_IDX_SINK_ENABLE: next_state.sinkEn = pwdata[7:0];
        `PDL_IDX_SINK_LVL_UP: next_state.lvlUp = pwdata[7:0];
        `PDL_IDX_SINK_LVL_LO: next_state.lvlLo = pwdata[7:0];
        default:              next_state.err = 1'b0;
      endcase
    end
  end

  // Synchronous reset clears all control state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // One driver per port keeps the pin logic in one place
  for (genvar p = 0; p < 4; p++) begin : gPort
    pdl_pin_drive uDrive (
      .clk       (clk),
      .reset_n   (reset_n),
      .outValue  (state.outVal[p]),
      .dirOut    (state.dir[p]),
      .altFunc   (state.alt[p]),
      .openDrain (state.od[p]),
      .pinOut    (pinO[p]),
      .pinOe_n   (pinOe[p])
    );
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.err;
  assign portAOut = pinO[0];
  assign portAOe_n = pinOe[0];
  assign portBOut = pinO[1];
  assign portBOe_n = pinOe[1];
  assign portCOut = pinO[2];
  assign portCOe_n = pinOe[2];
  assign portDOut = pinO[3];
  assign portDOe_n = pinOe[3];
  // Sink controls go straight out; alternate select plays no part
  assign sinkEnable = state.sinkEn;
  assign sinkLevelUpper = state.lvlUp;
  assign sinkLevelLower = state.lvlLo;

  // Checks; the APB steps are named once and shared by the properties
  // Access phase of a read to one index, one cycle before the answer
  sequence seqReadAcc(int idx);
    psel && penable && !pwrite && !pready && regIdx == idx
      && paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00;
  endsequence

  // Completing edge of a write to one index with byte lane 0 on
  sequence seqWriteAcc(int idx);
    psel && penable && pwrite && pready && pstrb[0] && regIdx == idx
      && paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00;
  endsequence

  AST_SAMPLE_READ: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqReadAcc(`PDL_IDX_PA_IN) |=> prdata[7:0] == $past(portAIn, 2))
    else $error("Port A sample read mismatch");

  AST_PORTB_SAMPLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqReadAcc(`PDL_IDX_PB_IN) |=> prdata[7:0] == $past(portBIn, 2))
    else $error("Port B sample read mismatch");

  AST_PORTC_SAMPLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqReadAcc(`PDL_IDX_PC_IN) |=> prdata[7:0] == $past(portCIn, 2))
    else $error("Port C sample read mismatch");

  AST_ABSENT_ZERO: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqReadAcc(`PDL_IDX_PD_IN) |=> pready && prdata == 32'h0000_0000)
    else $error("Absent port did not read zero");

  AST_DRIVE_GATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && (state.alt[0][0] || !state.dir[0][0])
      |=> portAOe_n[0])
    else $error("Pin driven while input or alternate");

  AST_DRIVE_ON: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n)
      |-> (portDOe_n & $past(state.dir[3] & ~state.alt[3] & ~state.od[3]))
        == 8'h00)
    else $error("Plain output pin left released");

  AST_OUT_FOLLOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> portCOut == $past(state.outVal[2]))
    else $error("Port C output lost its value");

  AST_OPEN_DRAIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) && state.od[1][0] && state.outVal[1][0]
      |=> portBOe_n[0])
    else $error("Open drain pin drove high");

  AST_RESET_ZERO: assert property (
    @(posedge clk)
    !reset_n |=> sinkEnable == 8'h00 && state.outVal == '0
      && sinkLevelUpper == 8'h00 && sinkLevelLower == 8'h00)
    else $error("Register not zero after reset");

  AST_OUT_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqWriteAcc(`PDL_IDX_PA_OUT) |=> state.outVal[0] == $past(pwdata[7:0]))
    else $error("Port A output write lost");

  AST_STRB_OFF: assert property (
    @(posedge clk) disable iff (!reset_n)
    psel && penable && pwrite && pready && !pstrb[0]
      |=> $stable(sinkEnable) && $stable(state.outVal))
    else $error("Write with byte lane off changed state");

  AST_SINK_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqWriteAcc(`PDL_IDX_SINK_ENABLE) |=> sinkEnable == $past(pwdata[7:0]))
    else $error("Sink enable write lost");

  AST_SINK_KEEP: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(wrTake && regIdx == `PDL_IDX_SINK_ENABLE) |=> $stable(sinkEnable))
    else $error("Sink enable changed without a write");

  AST_SINK_ALT: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(state.alt[2]) |-> $stable(sinkEnable))
    else $error("Alternate select disturbed sink");

  AST_LEVEL_MAP: assert property (
    @(posedge clk) disable iff (!reset_n)
    sinkMilliamp({sinkLevelUpper[0], sinkLevelLower[0]}) ==
      (sinkLevelUpper[0] ? (sinkLevelLower[0] ? 20 : 13)
                         : (sinkLevelLower[0] ? 7 : 3)))
    else $error("Sink level mapping wrong");

  AST_LEVEL_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqWriteAcc(`PDL_IDX_SINK_LVL_LO)
      |=> sinkLevelLower == $past(pwdata[7:0]))
    else $error("Sink lower level write lost");

  AST_INPUT_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqWriteAcc(`PDL_IDX_PA_IN) |=> $stable(state.outVal)
      && $stable(sinkEnable) && $stable(state.dir))
    else $error("Input write changed state");

  AST_INPUT_NO_ERR: assert property (
    @(posedge clk) disable iff (!reset_n)
    seqWriteAcc(`PDL_IDX_PC_IN) |-> !pslverr)
    else $error("Input write answered with an error");
endmodule

// file: test/pdl_pin_model.sv
// Pin model: resolves each pin from the block's drive and an outside source.
// Assumes Oe_n low means the block drives the pin; no pull on the pins.
`timescale 1ns/1ps
module pdl_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drvVal,
  input  wire logic [W-1:0] drvOe_n,
  input  wire logic [W-1:0] extVal,
  output logic      [W-1:0] level
);
  // Released pins follow the outside source, which the bench keeps moving
  assign level = (~drvOe_n & drvVal) | (drvOe_n & extVal);
endmodule

// file: test/port_data_led_drive_bench.sv
// Self-checking bench: APB master, register model and pin checks.
// Assumes the design package and defines header are compiled first.
`timescale 1ns/1ps
module port_data_led_drive_bench
  import pdl_pkg::*;
;
  logic             clk, reset_n, psel, penable, pwrite, err;
  logic      [15:0] paddr;
  logic      [31:0] pwdata, prdata, rnd, rd;
  logic      [3:0]  pstrb;
  logic             pready, pslverr;
  logic      [23:0] ext;
  logic      [7:0]  oe, o;
  pdl_byte_t        sinkEnable, sinkLevelUpper, sinkLevelLower;
  wire logic [31:0] allOut, allOe;
  wire logic [23:0] lvl;
  int               errors, comparisons;
  int               mdl[int];
  logic      [11:0] rw[$];
  pdl_sink_e        tab[4] = '{PDL_SINK_3MA, PDL_SINK_7MA, PDL_SINK_13MA,
                               PDL_SINK_20MA};

  pdl_port_data_led_drive dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portAIn(lvl[7:0]), .portBIn(lvl[15:8]), .portCIn(lvl[23:16]),
    .portAOut(allOut[7:0]), .portAOe_n(allOe[7:0]),
    .portBOut(allOut[15:8]), .portBOe_n(allOe[15:8]),
    .portCOut(allOut[23:16]), .portCOe_n(allOe[23:16]),
    .portDOut(allOut[31:24]), .portDOe_n(allOe[31:24]),
    .sinkEnable(sinkEnable), .sinkLevelUpper(sinkLevelUpper),
    .sinkLevelLower(sinkLevelLower));
  pdl_pin_model #(.W(24)) pins (.drvVal(allOut[23:0]),
    .drvOe_n(allOe[23:0]), .extVal(ext), .level(lvl));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Model keeps only the low byte; input indices have no entry
  task automatic wr_reg(input logic [11:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
    if (mdl.exists(idx)) mdl[idx] = v[7:0];
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk("prdata", rd, exp);
    chk("pslverr", {31'h0, err}, 32'h0000_0000);
  endtask

  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ext} = '0;
    pstrb = 4'hf;
    rnd = 32'h6330_1a11;
    rw = '{12'hf82, 12'hf83, 12'hf84, 12'hfd3, 12'hfd7, 12'hfdb, 12'hfdf};
    for (int i = 0; i < 12; i++) rw.push_back(12'(12'hfe0 + i));
    foreach (rw[i]) mdl[rw[i]] = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, then random write and read back of every register
    foreach (rw[i]) rd_chk(rw[i], 32'h0000_0000);
    chk("oe", allOe, 32'hffff_ffff);
    foreach (rw[i]) begin
      rnd = lfsr(rnd);
      wr_reg(rw[i], rnd);
    end
    foreach (rw[i]) rd_chk(rw[i], mdl[rw[i]]);
    // Writes to input indices change nothing; unmapped index is refused
    wr_reg(12'hfd2, ~rnd);
    chk("inErr", {31'h0, err}, 32'h0000_0000);
    wr_reg(12'hfda, rnd);
    foreach (rw[i]) rd_chk(rw[i], mdl[rw[i]]);
    apb(1'b0, 12'hf90, 32'h0000_0000);
    chk("unmapped", {31'h0, err}, 32'h0000_0001);
    // Byte lane 0 off: the write is dropped without an error
    pstrb <= 4'he;
    apb(1'b1, 12'hf82, ~mdl[12'hf82]);
    pstrb <= 4'hf;
    rd_chk(12'hf82, mdl[12'hf82]);
    // Random direction, alternate, open drain and value per port
    for (int r = 0; r < 8; r++) begin
      for (int p = 0; p < 4; p++) begin
        for (int k = 0; k < 4; k++) begin
          rnd = lfsr(rnd);
          wr_reg(k == 0 ? 12'(12'hfd3 + 4 * p) : 12'(12'hfdc + 4 * k + p),
                 rnd);
        end
      end
      rnd = lfsr(rnd);
      ext <= rnd[23:0];
      repeat (3) @(posedge clk);
      for (int p = 0; p < 4; p++) begin
        o = 8'(mdl[12'hfd3 + 4 * p]);
        oe = ~(8'(mdl[12'hfe0 + p]) & ~8'(mdl[12'hfe4 + p])
               & ~(8'(mdl[12'hfe8 + p]) & o));
        chk("pinOut", allOut[8*p+:8], o);
        chk("pinOe_n", allOe[8*p+:8], oe);
        if (p < 3) rd_chk(12'(12'hfd2 + 4 * p),
                          (~oe & o) | (oe & ext[8*p+:8]));
        else rd_chk(12'hfde, 32'h0000_0000);
      end
    end
    // Sink needs no alternate setting; each level code on its own pin
    for (int c = 0; c < 4; c++) begin
      // Alternate select of Port C toggles; the sink must not care
      wr_reg(12'hfe6, c[1] ? 32'h0000_0000 : 32'h0000_00ff);
      wr_reg(12'hf83, c[1] ? 32'h0000_00ff : 32'h0000_0000);
      wr_reg(12'hf84, c[0] ? 32'h0000_00ff : 32'h0000_0000);
      wr_reg(12'hf82, 32'h0000_0001 << (2 * c));
      repeat (2) @(posedge clk);
      chk("sinkEnable", sinkEnable, mdl[12'hf82]);
      chk("level", {sinkLevelUpper[2*c], sinkLevelLower[2*c]}, tab[c]);
    end
    give_verdict();
  end
endmodule
